/* File: design/sbc_spi_command_interface.sv */
`timescale 1ns/100ps
`include "sbc_spi_defs.svh"
module sbc_spi_command_interface
(
   // System clock and reset.
   input  wire logic               clock,
   input  wire logic               rst_n,
   // Serial link.
   input  wire logic               spi_clock,
   input  wire logic               chip_select_n,
   input  wire logic               serial_in,
   output logic                    serial_out,
   output logic                    serial_out_en,
   // Device pins and events.
   input  wire logic               reset_out_n,
   input  wire logic               fail_output,
   input  wire logic [7:0]         wake_event_a,
   input  wire logic [7:0]         wake_event_b,
   input  wire logic               wake_up,
   input  wire logic               restart_done,
   input  wire logic               fail_safe_enter,
   input  wire logic               fail_safe_exit,
   // Mode and control outputs.
   output sbc_spi_pkg::mode_e      device_mode,
   output logic                    cmd_fail,
   output logic                    interrupt_out_n,
   output logic                    watchdog_trigger,
   output logic [7:0]              watchdog_setting,
   output logic [7:0]              bus_control,
   output logic [7:0]              wake_control_a,
   output logic [7:0]              wake_control_b,
   output logic [7:0]              timer_control,
   output logic [7:0]              gpio_control,
   output logic [7:0]              hw_control,
   output logic                    wake_pin_measure_enable
);
   import sbc_spi_pkg::*;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   // Maps a frame address onto a bank index; unused addresses give none.
   function automatic reg_idx_t reg_index(input logic [6:0] addr);
      unique case (addr)
         `ADDR_MODE_CTRL:  reg_index = `IDX_MODE;
         `ADDR_HW_CTRL:    reg_index = `IDX_HW;
         `ADDR_WDOG_CTRL:  reg_index = `IDX_WDOG;
         `ADDR_BUS_CTRL:   reg_index = `IDX_BUS;
         `ADDR_WAKE_A:     reg_index = `IDX_WAKE_A;
         `ADDR_WAKE_B:     reg_index = `IDX_WAKE_B;
         `ADDR_TIMER_CTRL: reg_index = `IDX_TIMER;
         `ADDR_GPIO_CTRL:  reg_index = `IDX_GPIO;
         `ADDR_MEAS_CTRL:  reg_index = `IDX_MEAS;
         `ADDR_DEV_STAT:   reg_index = `IDX_DEV_STAT;
         `ADDR_WSTAT_A:    reg_index = `IDX_WSTAT_A;
         `ADDR_WSTAT_B:    reg_index = `IDX_WSTAT_B;
         default:          reg_index = `IDX_NONE;
      endcase
   endfunction : reg_index

   logic [7:0]  regs_r [0:15];
   logic [7:0]  shadow_r [0:15];
   logic [7:0]  stat_sh_r;
   mode_e       mode_r;
   mode_e       mode_nxt;

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------

   logic [4:0]  cnt_r;
   logic [15:0] rx_r;
   logic [4:0]  pos_r;
   logic        tx_bit_r;
   logic [4:0]  done_cnt_r;
   logic [15:0] done_rx_r;
   logic [6:0]  rd_addr_r;
   logic [4:0]  nb;
   reg_idx_t    rd_idx;

   // input sampled on falling edges
   // The count saturates so a long frame cannot wrap back to sixteen.
   always_ff @(negedge spi_clock or posedge chip_select_n)
   begin
      if (chip_select_n)
      begin
         cnt_r     <= 5'h00;
         rx_r      <= 16'h0000;
         rd_addr_r <= 7'h00;
      end
      else if (cnt_r != 5'h11)
      begin
         cnt_r <= cnt_r + 5'h01;
         if (cnt_r < `FRAME_BITS)
            rx_r <= {serial_in, rx_r[15:1]};
         // Bits enter at the top, so the address is caught whole on the seventh edge.
         if (cnt_r == 5'h06)
            rd_addr_r <= {serial_in, rx_r[15:10]};
      end
   end

   // frame captured at release
   // Release clears the live counters, so the word is held here for the system side.
   always_ff @(posedge chip_select_n or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_cnt_r <= 5'h00;
         done_rx_r  <= 16'h0000;
      end
      else
      begin
         done_cnt_r <= cnt_r;
         done_rx_r  <= rx_r;
      end
   end

   always_comb
   begin
      nb     = pos_r + 5'h01;
      rd_idx = reg_index(rd_addr_r);
   end

   // next bit after rising edge
   // Bits 0..7 carry the summary byte, bits 8..15 the addressed byte.
   always_ff @(posedge spi_clock or posedge chip_select_n)
   begin
      if (chip_select_n)
      begin
         pos_r    <= 5'h00;
         tx_bit_r <= 1'b0;
      end
      else if (pos_r != 5'h10)
      begin
         pos_r <= nb;
         if (nb < 5'h08)
            tx_bit_r <= stat_sh_r[nb[2:0]];
         else if (nb < `FRAME_BITS)
            tx_bit_r <= shadow_r[rd_idx][nb[2:0]];
         else
            tx_bit_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and frame supervision
   // ----------------------------------------------------------------

   logic cs_s1_r, cs_s2_r, cs_d_r;
   logic sck_s1_r, sck_s2_r;
   logic rst_s1_r, rst_s2_r;
   logic edge_hit_r, rst_hit_r, err_r;
   logic frame_start, frame_end, bad, exec;
   logic enabled;

   // Each pin passes two flops before the frame supervision looks at it; the serial output uses select and reset directly.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_s1_r  <= 1'b1;
         cs_s2_r  <= 1'b1;
         cs_d_r   <= 1'b1;
         sck_s1_r <= 1'b0;
         sck_s2_r <= 1'b0;
         rst_s1_r <= 1'b1;
         rst_s2_r <= 1'b1;
      end
      else
      begin
         cs_s1_r  <= chip_select_n;
         cs_s2_r  <= cs_s1_r;
         cs_d_r   <= cs_s2_r;
         sck_s1_r <= spi_clock;
         sck_s2_r <= sck_s1_r;
         rst_s1_r <= reset_out_n;
         rst_s2_r <= rst_s1_r;
      end
   end

   always_comb
   begin
      frame_start = cs_d_r & ~cs_s2_r;
      frame_end   = ~cs_d_r & cs_s2_r;
      enabled     = (mode_r == MODE_INIT) | (mode_r == MODE_NORMAL) | (mode_r == MODE_STOP);
      bad = edge_hit_r | sck_s2_r | rst_hit_r | ~rst_s2_r
          | ((done_cnt_r != 5'h00) & (done_cnt_r != `FRAME_BITS));
      exec = frame_end & ~bad & enabled & (done_cnt_r == `FRAME_BITS);
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         edge_hit_r <= 1'b0;
         rst_hit_r  <= 1'b0;
      end
      else if (frame_start)
      begin
         edge_hit_r <= sck_s2_r;
         rst_hit_r  <= ~rst_s2_r;
      end
      else if (~cs_s2_r & ~rst_s2_r)
         rst_hit_r <= 1'b1;
   end

   // error kept for next frame
   // A clean frame clears it, since that frame has already shown it.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         err_r <= 1'b0;
      else if (frame_end)
         err_r <= bad;
   end

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------

   logic [6:0] addr;
   logic       wr;
   logic [7:0] data;
   reg_idx_t   idx;
   logic       fail, wr_en, clr_en, int_req, wd_pulse, no_wake;
   logic [1:0] req;

   always_comb
   begin
      addr     = done_rx_r[`ADDR_HI:0];
      wr       = done_rx_r[`WR_BIT];
      data     = done_rx_r[15:`DATA_LO];
      idx      = reg_index(addr);
      req      = data[`MODE_HI:`MODE_LO];
      fail     = 1'b0;
      wr_en    = 1'b0;
      clr_en   = 1'b0;
      int_req  = 1'b0;
      wd_pulse = 1'b0;
      mode_nxt = mode_r;
      no_wake  = (regs_r[`IDX_BUS] == 8'h00) & (regs_r[`IDX_WAKE_A] == 8'h00)
               & (regs_r[`IDX_WAKE_B] == 8'h00) & (regs_r[`IDX_GPIO] == 8'h00);
      if (exec)
      begin
         if ((done_rx_r == 16'h0000) || (done_rx_r == 16'hFFFF))
            fail = 1'b1;
         else if (!wr || idx == `IDX_NONE)
            fail = 1'b0;
         else if (addr[`STATUS_ADDR_BIT])
            clr_en = 1'b1;
         else if (idx == `IDX_MODE)
         begin
            unique case (mode_r)
               MODE_INIT:
               begin
                  wr_en    = 1'b1;
                  fail     = (req == `REQ_STOP) | (req == `REQ_SLEEP);
                  mode_nxt = (req == `REQ_SOFT_RESET) ? MODE_RESTART : MODE_NORMAL;
               end
               MODE_NORMAL:
               begin
                  wr_en = 1'b1;
                  if (req == `REQ_SLEEP)
                  begin
                     fail     = no_wake;
                     mode_nxt = no_wake ? MODE_RESTART : MODE_SLEEP;
                  end
                  else if (req == `REQ_STOP)
                  begin
                     mode_nxt = MODE_STOP;
                     int_req  = (regs_r[`IDX_WSTAT_A] != 8'h00)
                              | (regs_r[`IDX_WSTAT_B] != 8'h00);
                  end
                  else if (req == `REQ_SOFT_RESET)
                     mode_nxt = MODE_RESTART;
               end
               default:
               begin
                  if (req == `REQ_NORMAL)
                     mode_nxt = MODE_NORMAL;
                  else if (req == `REQ_SOFT_RESET)
                     mode_nxt = MODE_RESTART;
                  else if (req == `REQ_SLEEP)
                  begin
                     fail     = 1'b1;
                     mode_nxt = MODE_RESTART;
                  end
               end
            endcase
         end
         else if (idx == `IDX_WDOG)
         begin
            if (^data)
               fail = 1'b1;
            else if ((mode_r == MODE_STOP) && (data != regs_r[`IDX_WDOG]))
               fail = 1'b1;
            else
            begin
               wd_pulse = 1'b1;
               wr_en    = 1'b1;
            end
         end
         else if (mode_r == MODE_STOP)
            fail = 1'b1;
         else if (idx == `IDX_TIMER)
         begin
            fail  = (data[`TIMER_PER_HI:`TIMER_PER_LO] != 4'h0)
                  & (data[`TIMER_ON_HI:`TIMER_ON_LO] >= data[`TIMER_PER_HI:`TIMER_PER_LO]);
            wr_en = ~fail;
         end
         else if (idx == `IDX_GPIO)
         begin
            fail  = regs_r[`IDX_MEAS][`MEAS_EN_BIT] & (data != regs_r[`IDX_GPIO]);
            wr_en = ~fail;
         end
         else if (idx == `IDX_MEAS)
         begin
            fail  = data[`MEAS_EN_BIT] & (fail_output | (regs_r[`IDX_GPIO] != 8'h00));
            wr_en = ~fail;
         end
         else if (idx == `IDX_DEV_STAT || idx == `IDX_WSTAT_A || idx == `IDX_WSTAT_B)
            fail = 1'b0;
         else
            wr_en = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------

   // writes land at release
   // Hardware set wins over a write-to-clear in the same cycle.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 16; i++)
            regs_r[i] <= `REG_RESET;
      end
      else
      begin
         if (wr_en)
            regs_r[idx] <= data;
         regs_r[`IDX_DEV_STAT][`CMD_FAIL_BIT] <= fail
            | (regs_r[`IDX_DEV_STAT][`CMD_FAIL_BIT] & ~(clr_en && idx == `IDX_DEV_STAT));
         regs_r[`IDX_WSTAT_A] <= wake_event_a
            | ((clr_en && idx == `IDX_WSTAT_A) ? 8'h00 : regs_r[`IDX_WSTAT_A]);
         regs_r[`IDX_WSTAT_B] <= wake_event_b
            | ((clr_en && idx == `IDX_WSTAT_B) ? 8'h00 : regs_r[`IDX_WSTAT_B]);
      end
   end

   // error leads the summary
   // The copy moves only while select is high, so the link reads a still word.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 16; i++)
            shadow_r[i] <= `REG_RESET;
         stat_sh_r <= 8'h00;
      end
      else if (cs_s2_r & cs_d_r)
      begin
         for (int i = 0; i < 16; i++)
            shadow_r[i] <= regs_r[i];
         stat_sh_r <= {regs_r[`IDX_DEV_STAT][`CMD_FAIL_BIT],
                       (regs_r[`IDX_WSTAT_A] != 8'h00) | (regs_r[`IDX_WSTAT_B] != 8'h00),
                       5'h00, err_r};
      end
   end

   // ----------------------------------------------------------------
   // Mode machine and pulses
   // ----------------------------------------------------------------

   logic [15:0] int_cnt_r;
   logic        timer_only_off;

   assign timer_only_off = (regs_r[`IDX_WAKE_A] == (8'h01 << `TIMER_WAKE_BIT))
      & (regs_r[`IDX_WAKE_B] == 8'h00) & (regs_r[`IDX_BUS] == 8'h00)
      & (regs_r[`IDX_GPIO] == 8'h00)
      & (regs_r[`IDX_TIMER][`TIMER_PER_HI:`TIMER_PER_LO] == 4'h0);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         mode_r <= MODE_INIT;
      else if (fail_safe_enter)
         mode_r <= MODE_FAILSAFE;
      else if (exec)
         mode_r <= mode_nxt;
      else if ((mode_r == MODE_SLEEP) && (wake_up || timer_only_off))
         mode_r <= MODE_RESTART;
      else if ((mode_r == MODE_RESTART) && restart_done)
         mode_r <= MODE_NORMAL;
      else if ((mode_r == MODE_FAILSAFE) && fail_safe_exit)
         mode_r <= MODE_RESTART;
   end

   // Interrupt is a fixed-width low pulse.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_cnt_r        <= 16'h0000;
         interrupt_out_n  <= 1'b1;
         watchdog_trigger <= 1'b0;
      end
      else
      begin
         if (int_req)
            int_cnt_r <= 16'(`INT_PULSE_CYC);
         else if (int_cnt_r != 16'h0000)
            int_cnt_r <= int_cnt_r - 16'h0001;
         interrupt_out_n  <= ~(int_req | (int_cnt_r > 16'h0001));
         watchdog_trigger <= wd_pulse;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // driven only while selected
   // Select and reset pins act at once; waiting for sync would miss bit 0.
   assign serial_out    = ~reset_out_n | ((pos_r == 5'h00) ? stat_sh_r[0] : tx_bit_r);
   assign serial_out_en = ~chip_select_n & (enabled | ~reset_out_n);

   assign device_mode             = mode_r;
   assign cmd_fail                = regs_r[`IDX_DEV_STAT][`CMD_FAIL_BIT];
   assign watchdog_setting        = regs_r[`IDX_WDOG];
   assign bus_control             = regs_r[`IDX_BUS];
   assign wake_control_a          = regs_r[`IDX_WAKE_A];
   assign wake_control_b          = regs_r[`IDX_WAKE_B];
   assign timer_control           = regs_r[`IDX_TIMER];
   assign gpio_control            = regs_r[`IDX_GPIO];
   assign hw_control              = regs_r[`IDX_HW];
   assign wake_pin_measure_enable = regs_r[`IDX_MEAS][`MEAS_EN_BIT];

endmodule : sbc_spi_command_interface

/* File: dv/sbc_spi_command_interface_test.sv */
`timescale 1ns/100ps
`include "sbc_spi_defs.svh"
module sbc_spi_command_interface_test;
   import sbc_spi_pkg::*;
   logic        clock, rst_n, reset_out_n, restart_done, err;
   logic        spi_clock, chip_select_n, serial_in, serial_out, serial_out_en;
   logic        cmd_fail, interrupt_out_n, fo, meas;
   logic [7:0]  wake_event_a, hw_control, timer_control, watchdog_setting, gpio_control;
   logic [7:0]  d, h, t;
   logic [15:0] rx;
   mode_e       device_mode;
   int          error_cnt, n_tests;

   sbc_spi_command_interface u_dut (.clock(clock), .rst_n(rst_n), .spi_clock(spi_clock),
      .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .reset_out_n(reset_out_n), .fail_output(fo),
      .wake_event_a(wake_event_a), .wake_event_b(8'h00), .wake_up(1'b0),
      .restart_done(restart_done), .fail_safe_enter(1'b0), .fail_safe_exit(1'b0),
      .device_mode(device_mode), .cmd_fail(cmd_fail), .interrupt_out_n(interrupt_out_n),
      .watchdog_trigger(), .watchdog_setting(watchdog_setting), .bus_control(),
      .wake_control_a(), .wake_control_b(), .timer_control(timer_control),
      .gpio_control(gpio_control), .hw_control(hw_control), .wake_pin_measure_enable(meas));
   spi_host_model u_host (.spi_clock(spi_clock), .chip_select_n(chip_select_n),
      .serial_in(serial_in), .serial_out(serial_out));

   // System clock, 4 ns period.
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // An on-time not below a running period is illegal.
   function automatic logic timer_bad(input logic [7:0] v);
      return (v[3:0] != 4'h0) && (v[7:4] >= v[3:0]);
   endfunction : timer_bad

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test

   // Decode lands within five clocks of release, so eight is ample.
   task automatic frame(input logic [7:0] v, input logic wr, input logic [6:0] a, input int n);
      @(negedge clock);
      u_host.xfer({v, wr, a}, n, rx, err);
      repeat (8) @(negedge clock);
   endtask : frame

   task automatic clear_fail(input logic e);
      frame(8'h00, 1'b1, `ADDR_DEV_STAT, 16);
      check("stat byte", 8'(rx[8]), 8'(e));
      check("summary fail", 8'(rx[7]), 8'(e));
      check("fail clr", 8'(cmd_fail), 8'h00);
   endtask : clear_fail

   task automatic mode_fail(input string what, input mode_e m, input logic f);
      check(what, 8'(device_mode), 8'(m));
      check("fail", 8'(cmd_fail), 8'(f));
   endtask : mode_fail

   // Hang guard, far beyond the roughly twelve microseconds the sequence needs.
   initial
   begin
      #100000;
      error_cnt++;
      stop_test();
   end

   // Main sequence.
   initial
   begin
      error_cnt = 0;
      n_tests = 0;
      rst_n = 1'b0;
      reset_out_n = 1'b1;
      restart_done = 1'b0;
      wake_event_a = 8'h00;
      fo = 1'b0;
      h = 8'h00;
      t = 8'h00;
      void'($urandom(32'h13FC));
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      frame(8'h40, 1'b1, `ADDR_MODE_CTRL, 16);
      mode_fail("init sleep", MODE_NORMAL, 1'b1);
      clear_fail(1'b1);
      frame(8'h40, 1'b1, `ADDR_MODE_CTRL, 16);
      mode_fail("no wake", MODE_RESTART, 1'b1);
      frame(8'h5A, 1'b1, `ADDR_HW_CTRL, 16);
      check("ignored", hw_control, h);
      @(negedge clock) restart_done = 1'b1;
      @(negedge clock) restart_done = 1'b0;
      clear_fail(1'b1);
      for (int i = 0; i < 4; i++)
      begin
         d = 8'($urandom);
         frame(d, 1'b1, `ADDR_HW_CTRL, 16);
         check("old byte", rx[15:8], h);
         check("err bit", 8'(err), 8'h00);
         h = d;
         check("hw", hw_control, h);
      end
      for (int i = 0; i < 6; i++)
      begin
         d = (i == 0) ? 8'h33 : (i == 1) ? 8'h34 : 8'($urandom);
         frame(d, 1'b1, `ADDR_TIMER_CTRL, 16);
         if (!timer_bad(d))
            t = d;
         check("timer", timer_control, t);
         clear_fail(timer_bad(d));
      end
      frame(8'h01, 1'b1, `ADDR_WDOG_CTRL, 16);
      check("wd odd", watchdog_setting, 8'h00);
      clear_fail(1'b1);
      frame(8'h03, 1'b1, `ADDR_WDOG_CTRL, 16);
      check("wd even", watchdog_setting, 8'h03);
      fo = 1'b1;
      frame(8'h01, 1'b1, `ADDR_MEAS_CTRL, 16);
      check("meas fo", 8'(meas), 8'h00);
      clear_fail(1'b1);
      fo = 1'b0;
      frame(8'h01, 1'b1, `ADDR_MEAS_CTRL, 16);
      check("meas on", 8'(meas), 8'h01);
      frame(8'h05, 1'b1, `ADDR_GPIO_CTRL, 16);
      check("gpio lock", gpio_control, 8'h00);
      clear_fail(1'b1);
      frame(8'hA5, 1'b1, `ADDR_HW_CTRL, 8);
      check("short", hw_control, h);
      frame(8'h00, 1'b0, 7'h00, 0);
      check("err set", 8'(err), 8'h01);
      frame(8'h00, 1'b0, 7'h00, 0);
      check("err clr", 8'(err), 8'h00);
      reset_out_n = 1'b0;
      frame(8'h00, 1'b0, 7'h00, 0);
      check("out high", 8'(err), 8'h01);
      reset_out_n = 1'b1;
      frame(8'h00, 1'b0, 7'h00, 0);
      check("rst err", 8'(err), 8'h01);
      @(negedge clock) wake_event_a = 8'h01;
      @(negedge clock) wake_event_a = 8'h00;
      frame(8'h80, 1'b1, `ADDR_MODE_CTRL, 16);
      mode_fail("to stop", MODE_STOP, 1'b0);
      check("int", 8'(interrupt_out_n), 8'h00);
      frame(8'h11, 1'b1, `ADDR_HW_CTRL, 16);
      check("stop hw", hw_control, h);
      clear_fail(1'b1);
      frame(8'h40, 1'b1, `ADDR_MODE_CTRL, 16);
      mode_fail("stop sleep", MODE_RESTART, 1'b1);
      stop_test();
   end
endmodule : sbc_spi_command_interface_test

/* File: dv/sbc_spi_monitor.sv */
`timescale 1ns/100ps
// Watches the system-side ports; serial timing is judged by the bench itself.
module sbc_spi_monitor
   import sbc_spi_pkg::*;
(
   // Clock and reset.
   input wire logic       clock,
   input wire logic       rst_n,
   // Link and pins.
   input wire logic       chip_select_n,
   input wire logic       serial_out,
   input wire logic       serial_out_en,
   input wire logic       reset_out_n,
   // Outputs of interest.
   input wire mode_e      device_mode,
   input wire logic       cmd_fail,
   input wire logic       interrupt_out_n,
   input wire logic       watchdog_trigger,
   input wire logic [7:0] hw_control,
   input wire logic [7:0] timer_control
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_out_float_idle: assert property (chip_select_n |-> !serial_out_en)
      else $error("serial output driven while deselected");
   a_out_high_rst: assert property (!reset_out_n && serial_out_en |-> serial_out)
      else $error("serial output not high while reset pin low");
   a_mode_gates_en: assert property (serial_out_en |-> !reset_out_n || device_mode inside
      {MODE_INIT, MODE_NORMAL, MODE_STOP}) else $error("output enabled in a disabled mode");
   a_en_in_frame: assert property (!chip_select_n && reset_out_n &&
      device_mode == MODE_NORMAL |-> serial_out_en) else $error("output not enabled in frame");
   a_fail_stays_set: assert property ((!chip_select_n)[*6] ##0 cmd_fail |=> cmd_fail)
      else $error("failure flag dropped inside a frame");
   a_regs_hold_frame: assert property ((!chip_select_n)[*6] |->
      $stable(hw_control) && $stable(timer_control)) else $error("register moved mid frame");
   a_trig_after_rel: assert property (watchdog_trigger |-> $past(chip_select_n, 3))
      else $error("watchdog trigger not tied to a release");
   a_int_on_stop: assert property ($fell(interrupt_out_n) |-> device_mode == MODE_STOP)
      else $error("interrupt outside stop entry");
   a_int_width_min: assert property ($fell(interrupt_out_n) |=> !interrupt_out_n[*8])
      else $error("interrupt pulse too short");
   a_stop_no_fail: assert property ($changed(device_mode) && device_mode == MODE_STOP
      |-> !$rose(cmd_fail)) else $error("stop entry flagged as failure");

   c_int: cover property ($fell(interrupt_out_n));
   c_fail: cover property ($rose(cmd_fail));
   c_trig: cover property (watchdog_trigger);
endmodule : sbc_spi_monitor

bind sbc_spi_command_interface sbc_spi_monitor u_mon (.*);

/* File: dv/spi_host_model.sv */
`timescale 1ns/100ps
// Controller on the serial link; its clock only runs inside frames.
module spi_host_model
(
   // Serial link.
   output logic      spi_clock,
   output logic      chip_select_n,
   output logic      serial_in,
   input  wire logic serial_out
);
   initial
   begin
      spi_clock = 1'b0;
      chip_select_n = 1'b1;
      serial_in = 1'b0;
   end

   // One frame of n clocks, LSB first; err is the first bit after select.
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx,
                       output logic err);
      rx = 16'h0000;
      spi_clock = 1'b0;
      chip_select_n = 1'b0;
      #12.5 err = serial_out;
      for (int i = 0; i < n; i++)
      begin
         serial_in = w[i];
         rx[i] = serial_out;
         spi_clock = 1'b1;
         #7.5 spi_clock = 1'b0;
         #7.5;
      end
      chip_select_n = 1'b1;
      // Released line shows garbage, never the last bit.
      serial_in = ~serial_in;
      #40;
   endtask : xfer
endmodule : spi_host_model

/* File: include/sbc_spi_defs.svh */
`ifndef SBC_SPI_DEFS_SVH
`define SBC_SPI_DEFS_SVH

// Frame shape.
`define FRAME_BITS      5'd16
`define ADDR_HI         6
`define WR_BIT          7
`define DATA_LO         8
`define STATUS_ADDR_BIT 6

// Register addresses.
`define ADDR_MODE_CTRL  7'h01
`define ADDR_HW_CTRL    7'h02
`define ADDR_WDOG_CTRL  7'h03
`define ADDR_BUS_CTRL   7'h04
`define ADDR_WAKE_A     7'h05
`define ADDR_WAKE_B     7'h06
`define ADDR_TIMER_CTRL 7'h0C
`define ADDR_GPIO_CTRL  7'h17
`define ADDR_MEAS_CTRL  7'h18
`define ADDR_DEV_STAT   7'h43
`define ADDR_WSTAT_A    7'h46
`define ADDR_WSTAT_B    7'h47

// Register bank indices.
`define IDX_MODE        4'h0
`define IDX_HW          4'h1
`define IDX_WDOG        4'h2
`define IDX_BUS         4'h3
`define IDX_WAKE_A      4'h4
`define IDX_WAKE_B      4'h5
`define IDX_TIMER       4'h6
`define IDX_GPIO        4'h7
`define IDX_MEAS        4'h8
`define IDX_DEV_STAT    4'h9
`define IDX_WSTAT_A     4'hA
`define IDX_WSTAT_B     4'hB
`define IDX_NONE        4'hF

// Field positions.
`define MODE_HI         7
`define MODE_LO         6
`define TIMER_ON_HI     7
`define TIMER_ON_LO     4
`define TIMER_PER_HI    3
`define TIMER_PER_LO    0
`define MEAS_EN_BIT     0
`define CMD_FAIL_BIT    0
`define TIMER_WAKE_BIT  0

// Requested mode codes in the mode field.
`define REQ_NORMAL      2'h0
`define REQ_SLEEP       2'h1
`define REQ_STOP        2'h2
`define REQ_SOFT_RESET  2'h3

// Reset value of every register byte.
`define REG_RESET       8'h00

// Interrupt pulse timing.
`define CLK_MHZ         250
`define INT_PULSE_NS    1000
`define INT_PULSE_CYC   ((`INT_PULSE_NS * `CLK_MHZ) / 1000)

`endif

/* File: include/sbc_spi_pkg.sv */
package sbc_spi_pkg;

   typedef enum logic [5:0] {
      MODE_INIT     = 6'h01,
      MODE_NORMAL   = 6'h02,
      MODE_STOP     = 6'h04,
      MODE_SLEEP    = 6'h08,
      MODE_RESTART  = 6'h10,
      MODE_FAILSAFE = 6'h20
   } mode_e;

   typedef logic [3:0] reg_idx_t;

endpackage : sbc_spi_pkg
